// file: external_bus_control.sv
// Purpose: control side of a processor external bus
// Assumes: core presents one access at a time and holds it until done pulses
// Notes: output enables are low while the pin is driven
// Functional notes
// - Ready low stalls one more cycle, then ready is sampled again.
// - Ready is only evaluated when two or more wait states are programmed.
// - Ready is not sampled before the programmed wait states elapse.
// - Read-not-write idles high, low only during an external write.
// - Read-not-write floats during grant or when outputs-off is low.
// - I/O strobe idles high, low only during an I/O access.
// - I/O strobe floats during grant or when outputs-off is low.
// - On grant, address, data and control float and acknowledge goes low.
// - Acknowledge is high during reset, floats when outputs-off is low.
// - Wait-microstate goes low at first wait state, high at last one, when two or more wait states are programmed.
// - Wait-microstate looped to ready gives exactly one extra wait state.
// - Wait-microstate floats when outputs-off is low.
// - Fetch flag low during instruction fetch address, floats on outputs-off.
// - Machine clock output is the cycle rate divided by 1 to 4.
// - After reset the machine clock divisor is four.
// - Space selects idle high, one low during its valid access.
// - Memory strobe low only for data or program accesses, floats on grant.
`timescale 1ns/10ps
`include "ext_bus_defines.svh"
module external_bus_control #(
    parameter int WAIT_W = `WAIT_W
) (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Core access request
    input wire logic access_req,
    input wire logic access_write,
    input wire ext_bus_pkg::space_t access_space,
    input wire logic access_fetch,
    input wire logic [WAIT_W-1:0] access_waits,
    output logic access_done,
    // Bank switch control field for the clock divider
    input wire logic [`CLK_DIV_W-1:0] clock_div_sel,
    input wire logic clock_div_load,
    // External handshake inputs
    input wire logic ready,
    input wire logic bus_grab_req_n,
    input wire logic all_outputs_off_n,
    // Bus pins, value and output enable (low drives)
    output logic read_not_write,
    output logic read_not_write_oe_n,
    output logic io_space_strobe_n,
    output logic io_space_strobe_oe_n,
    output logic memory_space_strobe_n,
    output logic memory_space_strobe_oe_n,
    output logic data_space_select_n,
    output logic program_space_select_n,
    output logic io_space_select_n,
    output logic space_select_oe_n,
    output logic bus_grab_ack_n,
    output logic bus_grab_ack_oe_n,
    output logic wait_microstate_done_n,
    output logic wait_microstate_done_oe_n,
    output logic instr_fetch_flag_n,
    output logic instr_fetch_flag_oe_n,
    output logic machine_clock_out,
    output logic machine_clock_out_oe_n,
    // Address and data bus float control for the core's bus drivers
    output logic addr_data_oe_n
);

    ////////////////////////////////////////////////////////////////////////
    // Access sequencer

    ext_bus_pkg::bus_state_t state;
    ext_bus_pkg::bus_state_t next_state;
    logic [WAIT_W-1:0] wait_count;
    logic [WAIT_W-1:0] next_wait_count;
    logic [WAIT_W-1:0] waits;
    logic [WAIT_W-1:0] next_waits;
    logic write_q;
    logic next_write_q;
    logic fetch_q;
    logic next_fetch_q;
    ext_bus_pkg::space_t space_q;
    ext_bus_pkg::space_t next_space_q;
    logic msc_n;
    logic next_msc_n;
    logic [`CLK_DIV_W-1:0] div_sel;
    logic [`CLK_DIV_W-1:0] next_div_sel;

    function automatic logic uses_ready(input logic [WAIT_W-1:0] n);
        uses_ready = (n >= WAIT_W'(`READY_MIN_WAITS));
    endfunction

    always_comb begin
        next_state = state;
        next_wait_count = wait_count;
        next_waits = waits;
        next_write_q = write_q;
        next_fetch_q = fetch_q;
        next_space_q = space_q;
        next_msc_n = msc_n;
        case (state)
            ext_bus_pkg::st_idle: begin
                // Grant is checked first only at a transaction boundary
                if (!bus_grab_req_n) begin
                    next_state = ext_bus_pkg::st_grant;
                end else if (access_req) begin
                    next_write_q = access_write;
                    next_fetch_q = access_fetch;
                    next_space_q = access_space;
                    next_waits = access_waits;
                    next_wait_count = '0;
                    if (access_waits == '0) begin
                        next_state = ext_bus_pkg::st_done;
                    end else begin
                        next_state = ext_bus_pkg::st_soft_wait;
                        // Goes low at the start of the first wait state
                        if (uses_ready(access_waits)) begin
                            next_msc_n = 1'b0;
                        end
                    end
                end
            end
            ext_bus_pkg::st_soft_wait: begin
                next_wait_count = wait_count + WAIT_W'(1);
                // Back high at the start of the last wait state
                if (next_wait_count == waits - WAIT_W'(1)) begin
                    next_msc_n = 1'b1;
                end
                if (next_wait_count == waits) begin
                    // Ready is first looked at once the last wait state has ended,
                    // so a looped-back wait-microstate pin costs one external cycle
                    if (uses_ready(waits)) begin
                        next_state = ext_bus_pkg::st_ready_wait;
                    end else begin
                        next_state = ext_bus_pkg::st_done;
                    end
                end
            end
            ext_bus_pkg::st_ready_wait: begin
                // One more cycle per low sample; relies on the slave holding it
                if (ready) begin
                    next_state = ext_bus_pkg::st_done;
                end
            end
            ext_bus_pkg::st_done: begin
                next_state = ext_bus_pkg::st_idle;
            end
            ext_bus_pkg::st_grant: begin
                // Master keeps the request low for as long as it owns the bus
                if (bus_grab_req_n) begin
                    next_state = ext_bus_pkg::st_idle;
                end
            end
            default: begin
                next_state = ext_bus_pkg::st_idle;
            end
        endcase
        if (clock_div_load) begin
            next_div_sel = clock_div_sel;
        end else begin
            next_div_sel = div_sel;
        end
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            state <= ext_bus_pkg::st_idle;
            wait_count <= '0;
            waits <= '0;
            write_q <= 1'b0;
            fetch_q <= 1'b0;
            space_q <= ext_bus_pkg::space_data;
            msc_n <= 1'b1;
            div_sel <= `CLK_DIV_RESET;
        end else begin
            state <= next_state;
            wait_count <= next_wait_count;
            waits <= next_waits;
            write_q <= next_write_q;
            fetch_q <= next_fetch_q;
            space_q <= next_space_q;
            msc_n <= next_msc_n;
            div_sel <= next_div_sel;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Machine clock divider

    clock_div_if div_link ();

    assign div_link.div_sel = div_sel;

    clock_divider u_div (
        .clock(clock),
        .rst(rst),
        .link(div_link)
    );

    ////////////////////////////////////////////////////////////////////////
    // Pin outputs

    logic active;
    logic granted;
    logic next_rnw;
    logic next_io_strobe_n;
    logic next_mem_strobe_n;
    logic next_ds_n;
    logic next_ps_n;
    logic next_is_n;
    logic next_iaq_n;
    logic next_ack_n;
    logic rnw_q;
    logic io_strobe_q;
    logic mem_strobe_q;
    logic ds_q;
    logic ps_q;
    logic is_q;
    logic iaq_q;
    logic ack_q;

    assign access_done = (state == ext_bus_pkg::st_done);
    assign granted = (next_state == ext_bus_pkg::st_grant);
    assign active = (next_state == ext_bus_pkg::st_soft_wait)
                 || (next_state == ext_bus_pkg::st_ready_wait)
                 || (next_state == ext_bus_pkg::st_done);

    always_comb begin
        next_rnw = !(active && next_write_q);
        next_io_strobe_n = !(active && next_space_q == ext_bus_pkg::space_io);
        next_mem_strobe_n = !(active && next_space_q != ext_bus_pkg::space_io);
        next_ds_n = !(active && next_space_q == ext_bus_pkg::space_data);
        next_ps_n = !(active && next_space_q == ext_bus_pkg::space_prog);
        next_is_n = !(active && next_space_q == ext_bus_pkg::space_io);
        next_iaq_n = !(active && next_fetch_q);
        next_ack_n = !granted;
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            rnw_q <= 1'b1;
            io_strobe_q <= 1'b1;
            mem_strobe_q <= 1'b1;
            ds_q <= 1'b1;
            ps_q <= 1'b1;
            is_q <= 1'b1;
            iaq_q <= 1'b1;
            ack_q <= 1'b1;
        end else begin
            rnw_q <= next_rnw;
            io_strobe_q <= next_io_strobe_n;
            mem_strobe_q <= next_mem_strobe_n;
            ds_q <= next_ds_n;
            ps_q <= next_ps_n;
            is_q <= next_is_n;
            iaq_q <= next_iaq_n;
            ack_q <= next_ack_n;
        end
    end

    assign read_not_write = rnw_q;
    assign io_space_strobe_n = io_strobe_q;
    assign memory_space_strobe_n = mem_strobe_q;
    assign data_space_select_n = ds_q;
    assign program_space_select_n = ps_q;
    assign io_space_select_n = is_q;
    assign instr_fetch_flag_n = iaq_q;
    assign bus_grab_ack_n = ack_q;
    assign wait_microstate_done_n = msc_n;
    assign machine_clock_out = div_link.clk_out;

    // Hold floats the bus but not the acknowledge itself; outputs-off floats all
    logic hold_float;
    assign hold_float = !ack_q;
    assign read_not_write_oe_n = hold_float || !all_outputs_off_n;
    assign io_space_strobe_oe_n = hold_float || !all_outputs_off_n;
    assign memory_space_strobe_oe_n = hold_float || !all_outputs_off_n;
    assign space_select_oe_n = hold_float || !all_outputs_off_n;
    assign addr_data_oe_n = hold_float || !all_outputs_off_n;
    // Reset keeps the acknowledge driven high unless outputs-off is low
    assign bus_grab_ack_oe_n = !all_outputs_off_n;
    assign wait_microstate_done_oe_n = !all_outputs_off_n;
    assign instr_fetch_flag_oe_n = !all_outputs_off_n;
    assign machine_clock_out_oe_n = !all_outputs_off_n;
endmodule

// file: ext_bus_defines.svh
// Purpose: constants for the external bus control block
// Assumes: one machine-cycle clock
// Notes: divisor codes follow the bank switch field encoding
`ifndef EXT_BUS_DEFINES_SVH
`define EXT_BUS_DEFINES_SVH
`define CLK_DIV_W 2
`define CLK_DIV_RESET 2'h3
`define WAIT_W 3
`define READY_MIN_WAITS 3'h2
`endif

// file: ext_bus_pkg.sv
// Purpose: types for the external bus control block
// Assumes: nothing
// Notes: none
package ext_bus_pkg;
    typedef enum logic [1:0] {
        space_data,
        space_prog,
        space_io
    } space_t;
    typedef enum {
        st_idle,
        st_soft_wait,
        st_ready_wait,
        st_done,
        st_grant
    } bus_state_t;
endpackage

// file: clock_div_if.sv
// Purpose: carries divisor setting to the clock divider
// Assumes: one clock domain
// Notes: none
`timescale 1ns/10ps
`include "ext_bus_defines.svh"
interface clock_div_if;
    logic [`CLK_DIV_W-1:0] div_sel;
    logic clk_out;
    modport ctrl (output div_sel, input clk_out);
    modport div (input div_sel, output clk_out);
endinterface

// file: clock_divider.sv
// Purpose: divided machine clock output
// Assumes: div_sel code n divides by n+1
// Notes: a new divisor takes effect on the next clock, changing the length of the current period
`timescale 1ns/10ps
`include "ext_bus_defines.svh"
module clock_divider (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Divisor and output
    clock_div_if.div link
);
    logic [`CLK_DIV_W-1:0] count;
    logic [`CLK_DIV_W-1:0] next_count;
    logic out;
    logic next_out;

    always_comb begin
        next_count = count;
        next_out = out;
        if (count >= link.div_sel) begin
            next_count = '0;
        end else begin
            next_count = count + 2'h1;
        end
        // High for the first half of each period, rounded up
        next_out = (next_count <= (link.div_sel >> 1));
    end

    always_ff @(posedge clock) begin
        if (rst) begin
            count <= '0;
            out <= 1'b1;
        end else begin
            count <= next_count;
            out <= next_out;
        end
    end

    assign link.clk_out = out;
endmodule

// file: ext_bus_props.sv
// Purpose: protocol checks on the external bus control pins
// Assumes: one clock, synchronous reset
// Notes: bound to every bus control instance
`timescale 1ns/10ps
module ext_bus_props (
    // Clock and reset
    input wire logic clock,
    input wire logic rst,
    // Handshakes
    input wire logic ready,
    input wire logic all_outputs_off_n,
    input wire logic access_done,
    // Pins and enables
    input wire logic read_not_write,
    input wire logic read_not_write_oe_n,
    input wire logic io_space_strobe_n,
    input wire logic io_space_strobe_oe_n,
    input wire logic memory_space_strobe_n,
    input wire logic memory_space_strobe_oe_n,
    input wire logic data_space_select_n,
    input wire logic program_space_select_n,
    input wire logic io_space_select_n,
    input wire logic bus_grab_ack_n,
    input wire logic bus_grab_ack_oe_n,
    input wire logic wait_microstate_done_n,
    input wire logic wait_microstate_done_oe_n,
    input wire logic instr_fetch_flag_n,
    input wire logic instr_fetch_flag_oe_n,
    input wire logic addr_data_oe_n
);
    default clocking @(posedge clock); endclocking
    default disable iff (rst);
    logic active;
    assign active = !memory_space_strobe_n || !io_space_strobe_n;
    property p_stall;
        $rose(wait_microstate_done_n) && !ready |=> !access_done;
    endproperty
    a_stall: assert property (p_stall) else $error("done with ready low");
    property p_rnw; !read_not_write |-> active; endproperty
    a_rnw: assert property (p_rnw) else $error("write outside access");
    property p_io; !io_space_strobe_n |-> !io_space_select_n && memory_space_strobe_n; endproperty
    a_io: assert property (p_io) else $error("io strobe wrong");
    property p_mem;
        !memory_space_strobe_n |-> !data_space_select_n || !program_space_select_n;
    endproperty
    a_mem: assert property (p_mem) else $error("memory strobe wrong");
    property p_float;
        !bus_grab_ack_n |-> read_not_write_oe_n && io_space_strobe_oe_n
            && memory_space_strobe_oe_n && addr_data_oe_n;
    endproperty
    a_float: assert property (p_float) else $error("driven in grant");
    property p_off;
        !all_outputs_off_n |-> bus_grab_ack_oe_n && wait_microstate_done_oe_n
            && instr_fetch_flag_oe_n;
    endproperty
    a_off: assert property (p_off) else $error("driven when off");
    property p_ack_rst; disable iff (1'b0) rst |=> bus_grab_ack_n; endproperty
    a_ack_rst: assert property (p_ack_rst) else $error("ack low in reset");
    property p_edge; $fell(bus_grab_ack_n) |-> !$past(active); endproperty
    a_edge: assert property (p_edge) else $error("grant mid access");
    property p_msc; $fell(wait_microstate_done_n) |-> active; endproperty
    a_msc: assert property (p_msc) else $error("wait state idle");
    property p_fetch; !instr_fetch_flag_n |-> !program_space_select_n; endproperty
    a_fetch: assert property (p_fetch) else $error("fetch flag wrong");
    c_stall: cover property ($rose(wait_microstate_done_n) && !ready);
    c_grant: cover property ($fell(bus_grab_ack_n));
    c_io: cover property ($fell(io_space_strobe_n));
endmodule
bind external_bus_control ext_bus_props u_props (.*);

// file: bus_partner.sv
// Purpose: slow external device answering with ready
// Assumes: strobes mark the access
// Notes: loop ties ready to the wait-microstate pin
`timescale 1ns/10ps
module bus_partner (
    // Clock
    input wire logic clock,
    // Bus side
    input wire logic active_n,
    input wire logic msc_n,
    input wire logic loop,
    input wire logic [3:0] hold,
    output logic ready
);
    logic [3:0] count = 4'h0;
    always @(posedge clock) begin
        count <= active_n ? 4'h0 : count + 4'h1;
    end
    // Ready stays low until hold cycles of the access have passed
    assign ready = loop ? msc_n : (count >= hold);
endmodule

// file: tb_top.sv
// Purpose: self-checking bench for the external bus control
// Assumes: partner supplies ready
// Notes: inputs change on the falling edge
`timescale 1ns/10ps
module tb_top;
    logic clock, rst = 1'b1, access_req = 1'b0, access_write = 1'b0, access_fetch = 1'b0;
    logic clock_div_load = 1'b0, bus_grab_req_n = 1'b1, all_outputs_off_n = 1'b1, loop = 1'b0;
    logic [2:0] access_waits = 3'h0;
    logic [1:0] clock_div_sel = 2'h3;
    logic [3:0] hold = 4'h0;
    ext_bus_pkg::space_t access_space = ext_bus_pkg::space_data;
    logic ready, access_done, addr_data_oe_n, read_not_write, read_not_write_oe_n;
    logic io_space_strobe_n, io_space_strobe_oe_n, memory_space_strobe_n;
    logic memory_space_strobe_oe_n, data_space_select_n, program_space_select_n;
    logic io_space_select_n, space_select_oe_n, bus_grab_ack_n, bus_grab_ack_oe_n;
    logic wait_microstate_done_n, wait_microstate_done_oe_n, instr_fetch_flag_n;
    logic instr_fetch_flag_oe_n, machine_clock_out, machine_clock_out_oe_n;
    logic [5:0] pin_oe_n;
    int num_errors = 0;
    int comparisons = 0;
    assign pin_oe_n = {read_not_write_oe_n, io_space_strobe_oe_n, memory_space_strobe_oe_n,
        bus_grab_ack_oe_n, wait_microstate_done_oe_n, instr_fetch_flag_oe_n};
    external_bus_control u_dut (.*);
    bus_partner u_partner (
        .clock(clock),
        .active_n(memory_space_strobe_n & io_space_strobe_n),
        .msc_n(wait_microstate_done_n),
        .loop(loop),
        .hold(hold),
        .ready(ready)
    );
    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            num_errors++;
            $display("BAD at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tally_and_finish;
        if (num_errors == 0 && comparisons > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    task automatic clk_high(input logic [1:0] code, input logic load, input logic [7:0] exp);
        logic [7:0] n;
        n = 8'h00;
        clock_div_sel = code;
        clock_div_load = load;
        @(negedge clock);
        clock_div_load = 1'b0;
        // Let 8 cycles pass after the load before counting high cycles
        repeat (8) @(negedge clock);
        repeat (12) begin
            @(negedge clock);
            n = n + {7'h00, machine_clock_out};
        end
        chk(n, exp);
    endtask
    task automatic access(input logic wr, input ext_bus_pkg::space_t sp, input logic [2:0] w,
        input logic [3:0] h, input logic [7:0] lat);
        logic [7:0] n;
        logic [2:0] sel_n;
        n = 8'h00;
        // Selects ordered data, program, io
        sel_n = 3'h7;
        sel_n[2 - sp] = 1'b0;
        access_write = wr;
        access_space = sp;
        access_fetch = !sel_n[1];
        access_waits = w;
        hold = h;
        access_req = 1'b1;
        @(negedge clock);
        chk(read_not_write, !wr);
        chk({data_space_select_n, program_space_select_n, io_space_select_n}, sel_n);
        chk({io_space_strobe_n, memory_space_strobe_n}, {sel_n[0], !sel_n[0]});
        chk(instr_fetch_flag_n, sel_n[1]);
        while (access_done !== 1'b1 && n < 8'h28) begin
            @(negedge clock);
            n++;
        end
        access_req = 1'b0;
        chk(n, lat);
        @(negedge clock);
    endtask
    task automatic grab_mid;
        fork
            access(1'b0, ext_bus_pkg::space_data, 3'h2, 4'h8, 8'h09);
            begin
                repeat (2) @(negedge clock);
                bus_grab_req_n = 1'b0;
                repeat (4) @(negedge clock);
                chk(bus_grab_ack_n, 1'b1);
            end
        join
        @(negedge clock);
        chk(bus_grab_ack_n, 1'b0);
        chk({pin_oe_n[5:3], addr_data_oe_n, space_select_oe_n}, 8'h1f);
        bus_grab_req_n = 1'b1;
        @(negedge clock);
        chk(bus_grab_ack_n, 1'b1);
    endtask
    task automatic outputs_off;
        all_outputs_off_n = 1'b0;
        @(negedge clock);
        chk(pin_oe_n, 6'h3f);
        all_outputs_off_n = 1'b1;
        @(negedge clock);
        chk(pin_oe_n, 6'h00);
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(negedge clock);
        chk(bus_grab_ack_n, 1'b1);
        rst = 1'b0;
        @(negedge clock);
        clk_high(2'h3, 1'b0, 8'h06);
        clk_high(2'h0, 1'b1, 8'h0c);
        clk_high(2'h1, 1'b1, 8'h06);
        clk_high(2'h2, 1'b1, 8'h08);
        access(1'b0, ext_bus_pkg::space_data, 3'h0, 4'h0, 8'h00);
        access(1'b1, ext_bus_pkg::space_io, 3'h1, 4'hf, 8'h01);
        access(1'b0, ext_bus_pkg::space_prog, 3'h2, 4'h4, 8'h05);
        access(1'b1, ext_bus_pkg::space_data, 3'h4, 4'h3, 8'h05);
        access(1'b0, ext_bus_pkg::space_io, 3'h7, 4'h0, 8'h08);
        loop = 1'b1;
        access(1'b1, ext_bus_pkg::space_prog, 3'h2, 4'h0, 8'h03);
        loop = 1'b0;
        grab_mid();
        outputs_off();
        tally_and_finish();
    end
    initial begin
        repeat (1000) @(posedge clock);
        num_errors++;
        tally_and_finish();
    end
endmodule
